// >>> hdl/bte_pkg.sv
// Shared constants and types for the block transfer engine.
// Assumes one clock domain; registers live outside, values arrive as ports.
package bte_pkg;

   // ------------------------------------------------------------------
   // Register offsets of the host-visible map
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL0    = 8'h50;
   localparam logic [7:0] REG_OPER     = 8'h51;
   localparam logic [7:0] REG_SRC_BASE = 8'h54;
   localparam logic [7:0] REG_DST_BASE = 8'h58;
   localparam logic [7:0] REG_WIDTH    = 8'h5C;
   localparam logic [7:0] REG_HEIGHT   = 8'h5E;
   localparam logic [7:0] REG_FG_COLOR = 8'h63;
   localparam logic [7:0] REG_INT_STAT = 8'hF1;

   // ------------------------------------------------------------------
   // Bit positions
   // ------------------------------------------------------------------
   localparam int CTRL_START_BIT = 7;
   localparam int STAT_XFER_BIT  = 7;
   localparam int STAT_BUSY_BIT  = 6;
   localparam int INT_WR_BIT     = 0;
   localparam int INT_RD_BIT     = 1;
   localparam int LAYER_POS      = 15;

   // ------------------------------------------------------------------
   // Operation codes (low nibble of the operation byte)
   // ------------------------------------------------------------------
   localparam logic [3:0] OP_READ     = 4'h1;
   localparam logic [3:0] OP_MOVE_POS = 4'h2;
   localparam logic [3:0] OP_MOVE_NEG = 4'h3;
   localparam logic [3:0] OP_TWRITE   = 4'h4;
   localparam logic [3:0] OP_TMOVE    = 4'h5;
   localparam logic [3:0] OP_PFILL    = 4'h6;

   // ------------------------------------------------------------------
   // Defaults
   // ------------------------------------------------------------------
   localparam int PIX_W_DEF   = 16;
   localparam int DIM_W_DEF   = 10;
   localparam int ADDR_W_DEF  = 20;
   localparam int PITCH_DEF   = 800;
   localparam int LAYER_DEF   = 384000;
   localparam int FIFO_DEPTH  = 8;
   localparam int PAT_SMALL   = 8;
   localparam int PAT_LARGE   = 16;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_SRC   = 6'h02,
      ST_DST   = 6'h04,
      ST_WR    = 6'h08,
      ST_HOST  = 6'h10,
      ST_DRAIN = 6'h20
   } bte_state_t;

endpackage

// >>> hdl/bte_fifo_if.sv
// Carrier between the engine and its pixel FIFO.
// Assumes both ends run on the same clock.
interface bte_fifo_if #(parameter int W = 16);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;
   logic         clr;

   modport fifo (input in_valid, in_data, out_ready, clr,
                 output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready, clr,
                 input in_ready, out_valid, out_data);
endinterface

// >>> hdl/bte_fifo.sv
// Pixel FIFO with valid/ready on both sides and a synchronous flush.
// Assumes clr, pushes and pops all come from the clk_i domain.
module bte_fifo
   import bte_pkg::*;
#(
   parameter int W     = PIX_W_DEF,
   parameter int DEPTH = FIFO_DEPTH
)(
   // Clock, reset and enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic en_i,
   // Queue ports
   bte_fifo_if.fifo f
);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PW) != DEPTH || W < 1)
   begin : g_bad
      $error("bte_fifo: DEPTH must be a power of two >= 2");
   end

   logic [W-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0]   cnt_q;
   logic          push;
   logic          pop;

   assign f.in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign f.out_valid = (cnt_q != '0);
   assign f.out_data  = mem_q[rd_q];
   assign push = f.in_valid & f.in_ready;
   assign pop  = f.out_valid & f.out_ready;

   always_ff @(posedge clk_i)
   begin
      if (en_i && push)
         mem_q[wr_q] <= f.in_data;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i || (en_i && f.clr))
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else if (en_i)
      begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end
endmodule

// >>> hdl/bte_engine.sv
// Two-dimensional block transfer engine: burst read, move with raster op,
// transparent write, transparent move and pattern fill.
// Assumes host ports and display memory port share clk_i.
// Contract
// - A burst read stays active until every word has been handed over.
// - Word count is block width times block height.
// - Start bit launches the operation with programmed source, dest, size.
// - Main status busy bit shows the whole operation in progress.
// - Burst read raises read flag; host clears it by writing one.
// - Host write raises write flag; host clears it by writing one.
// - Code 2h copies source to dest through raster op, ascending.
// - Moves accept linear or rectangular source and destination.
// - Code 3h walks from last elements backward to the start.
// - Transparent write skips pixels equal to the foreground colour.
// - Code C4h transparent write supports linear and block destination.
// - Transparent write stays active until every pixel written or skipped.
// - Code 5h transparent move, ascending only, skips key pixels.
// - Overlapping transparent move may alter source; not prevented.
// - Code 06h tiles 8x8 or 16x16 pattern with raster op.
// - Bit 7 of upper vertical address selects the layer.
// - Linear area is one run of width times height.
module bte_engine
   import bte_pkg::*;
#(
   parameter int PIX_W       = PIX_W_DEF,
   parameter int DIM_W       = DIM_W_DEF,
   parameter int ADDR_W      = ADDR_W_DEF,
   parameter int PITCH       = PITCH_DEF,
   parameter int LAYER_WORDS = LAYER_DEF,
   parameter int DEPTH       = FIFO_DEPTH
)(
   // Clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              en_i,
   // Configuration
   input  wire logic              start_i,
   input  wire logic [7:0]        oper_i,
   input  wire logic [15:0]       src_hpos_i,
   input  wire logic [15:0]       src_vpos_i,
   input  wire logic [15:0]       dst_hpos_i,
   input  wire logic [15:0]       dst_vpos_i,
   input  wire logic              src_linear_i,
   input  wire logic              dst_linear_i,
   input  wire logic              pat16_i,
   input  wire logic [DIM_W-1:0]  width_i,
   input  wire logic [DIM_W-1:0]  height_i,
   input  wire logic [PIX_W-1:0]  fg_color_i,
   input  wire logic              int_rd_en_i,
   input  wire logic              int_wr_en_i,
   input  wire logic              int_rd_clr_i,
   input  wire logic              int_wr_clr_i,
   // Status
   output logic                   ctrl_start_o,
   output logic                   stat_busy_o,
   output logic                   stat_xfer_o,
   output logic                   int_rd_flag_o,
   output logic                   int_wr_flag_o,
   output logic                   irq_n_o,
   // Host data port
   input  wire logic              host_wr_valid_i,
   input  wire logic [PIX_W-1:0]  host_wr_data_i,
   output logic                   host_wr_ready_o,
   output logic                   host_rd_valid_o,
   output logic [PIX_W-1:0]       host_rd_data_o,
   input  wire logic              host_rd_ready_i,
   // Display memory port
   output logic                   mem_req_o,
   output logic                   mem_we_o,
   output logic [ADDR_W-1:0]      mem_addr_o,
   output logic [PIX_W-1:0]       mem_wdata_o,
   input  wire logic              mem_gnt_i,
   input  wire logic              mem_rvalid_i,
   input  wire logic [PIX_W-1:0]  mem_rdata_i
);
   localparam int CNT_W = 2 * DIM_W;
   localparam logic [ADDR_W-1:0] PITCH_A = ADDR_W'(PITCH);
   localparam logic [ADDR_W-1:0] LAYER_A = ADDR_W'(LAYER_WORDS);

   if (DIM_W < 4 || DIM_W > 15 || ADDR_W < CNT_W || PIX_W < 1)
   begin : g_bad
      $error("bte_engine: unsupported DIM_W, ADDR_W or PIX_W");
   end

   // ------------------------------------------------------------------
   // Captured configuration
   // ------------------------------------------------------------------
   logic [3:0]        op_q;
   logic [3:0]        rop_q;
   logic [15:0]       sh_q, sv_q, dh_q, dv_q;
   logic              slin_q, dlin_q, pat16_q;
   logic [DIM_W-1:0]  w_q, h_q;
   logic [CNT_W-1:0]  total_q;
   logic [PIX_W-1:0]  fg_q;

   bte_state_t        state_q;
   logic              busy_q, arm_q, pend_q;
   logic [DIM_W-1:0]  x_q, y_q;
   logic [CNT_W-1:0]  idx_q;
   logic [PIX_W-1:0]  src_q, dst_q;
   logic              rd_flag_q, wr_flag_q, irq_n_q;
   logic [ADDR_W-1:0] addr_q;
   logic [PIX_W-1:0]  wdata_q;

   logic start_ok, neg, last, step, rd_done, wr_done;
   logic host_hit, mem_hit, rop_mode;
   logic [PIX_W-1:0]  rop_res;
   logic [ADDR_W-1:0] src_addr, dst_addr, addr_d;
   logic [CNT_W-1:0]  lin_off;
   logic [7:0]        pat_off;

   bte_fifo_if #(.W(PIX_W)) fq ();

   assign start_ok = start_i & ~busy_q & (width_i != '0)
                   & (height_i != '0);
   assign neg      = (op_q == OP_MOVE_NEG);
   assign last     = (idx_q == total_q - 1'b1);
   assign rop_mode = (op_q == OP_MOVE_POS) | neg | (op_q == OP_PFILL);

   // ------------------------------------------------------------------
   // Configuration capture at start
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         op_q    <= '0;
         rop_q   <= '0;
         sh_q    <= '0;
         sv_q    <= '0;
         dh_q    <= '0;
         dv_q    <= '0;
         slin_q  <= 1'b0;
         dlin_q  <= 1'b0;
         pat16_q <= 1'b0;
         w_q     <= '0;
         h_q     <= '0;
         total_q <= '0;
         fg_q    <= '0;
      end
      else if (en_i && start_ok)
      begin
         op_q    <= oper_i[3:0];
         rop_q   <= oper_i[7:4];
         sh_q    <= src_hpos_i;
         sv_q    <= src_vpos_i;
         dh_q    <= dst_hpos_i;
         dv_q    <= dst_vpos_i;
         slin_q  <= src_linear_i;
         dlin_q  <= dst_linear_i;
         pat16_q <= pat16_i;
         w_q     <= width_i;
         h_q     <= height_i;
         total_q <= CNT_W'(width_i) * CNT_W'(height_i);
         fg_q    <= fg_color_i;
      end
   end

   // ------------------------------------------------------------------
   // Addressing and raster op
   // ------------------------------------------------------------------
   function automatic logic [ADDR_W-1:0] area_addr(
      input logic [15:0]      hp,
      input logic [15:0]      vp,
      input logic             lin,
      input logic [CNT_W-1:0] loff,
      input logic [DIM_W-1:0] x,
      input logic [DIM_W-1:0] y
   );
      logic [ADDR_W-1:0] base;
      base = (vp[LAYER_POS] ? LAYER_A : '0)
           + ADDR_W'(vp[DIM_W-1:0]) * PITCH_A + ADDR_W'(hp[DIM_W-1:0]);
      if (lin)
         return base + ADDR_W'(loff);
      return base + ADDR_W'(y) * PITCH_A + ADDR_W'(x);
   endfunction

   assign lin_off = neg ? (total_q - 1'b1 - idx_q) : idx_q;
   assign pat_off = pat16_q ? {y_q[3:0], x_q[3:0]}
                            : {2'b00, y_q[2:0], x_q[2:0]};

   always_comb
   begin
      dst_addr = area_addr(dh_q, dv_q, dlin_q, lin_off, x_q, y_q);
      if (op_q == OP_PFILL)
         src_addr = area_addr(sh_q, sv_q, 1'b1, CNT_W'(pat_off), x_q, y_q);
      else
         src_addr = area_addr(sh_q, sv_q, slin_q, lin_off, x_q, y_q);
      addr_d = (state_q == ST_SRC) ? src_addr : dst_addr;
   end

   for (genvar i = 0; i < PIX_W; i++)
   begin : g_rop
      assign rop_res[i] = rop_q[{src_q[i], dst_q[i]}];
   end

   // ------------------------------------------------------------------
   // Handshake terms
   // ------------------------------------------------------------------
   assign rd_done  = pend_q & mem_rvalid_i;
   assign wr_done  = mem_req_o & mem_we_o & mem_gnt_i;
   assign mem_hit  = (mem_rdata_i == fg_q);
   assign host_hit = (fq.out_data == fg_q);

   always_comb
   begin
      step = 1'b0;
      case (state_q)
         ST_SRC:
            step = rd_done & ((op_q == OP_READ)
                 | ((op_q == OP_TMOVE) & mem_hit));
         ST_HOST:
            step = fq.out_valid & host_hit;
         ST_WR:
            step = wr_done;
         default:
            step = 1'b0;
      endcase
   end

   assign mem_we_o  = (state_q == ST_WR);
   assign mem_req_o = en_i & arm_q & (((state_q == ST_SRC) & ~pend_q
                    & ((op_q != OP_READ) | fq.in_ready))
                    | ((state_q == ST_DST) & ~pend_q)
                    | (state_q == ST_WR));
   assign mem_addr_o  = addr_q;
   assign mem_wdata_o = wdata_q;

   // ------------------------------------------------------------------
   // Element walk
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         idx_q <= '0;
         x_q   <= '0;
         y_q   <= '0;
      end
      else if (en_i && start_ok)
      begin
         idx_q <= '0;
         x_q   <= (oper_i[3:0] == OP_MOVE_NEG) ? width_i - 1'b1 : '0;
         y_q   <= (oper_i[3:0] == OP_MOVE_NEG) ? height_i - 1'b1 : '0;
      end
      else if (en_i && step)
      begin
         idx_q <= idx_q + 1'b1;
         if (neg)
         begin
            x_q <= (x_q == '0) ? w_q - 1'b1 : x_q - 1'b1;
            if (x_q == '0)
               y_q <= y_q - 1'b1;
         end
         else
         begin
            x_q <= (x_q == w_q - 1'b1) ? '0 : x_q + 1'b1;
            if (x_q == w_q - 1'b1)
               y_q <= y_q + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_IDLE;
         busy_q  <= 1'b0;
         arm_q   <= 1'b0;
         pend_q  <= 1'b0;
         src_q   <= '0;
         dst_q   <= '0;
      end
      else if (en_i)
      begin
         arm_q <= 1'b1;
         if (mem_req_o && mem_gnt_i && !mem_we_o)
            pend_q <= 1'b1;
         if (rd_done)
            pend_q <= 1'b0;
         case (state_q)
            ST_IDLE:
               if (start_ok)
               begin
                  busy_q  <= 1'b1;
                  arm_q   <= 1'b0;
                  state_q <= (oper_i[3:0] == OP_TWRITE) ? ST_HOST : ST_SRC;
               end
            ST_SRC:
               if (rd_done)
               begin
                  src_q   <= mem_rdata_i;
                  arm_q   <= 1'b0;
                  state_q <= (op_q == OP_TMOVE) ? ST_WR : ST_DST;
               end
            ST_DST:
               if (rd_done)
               begin
                  dst_q   <= mem_rdata_i;
                  arm_q   <= 1'b0;
                  state_q <= ST_WR;
               end
            ST_HOST:
               if (fq.out_valid)
               begin
                  src_q   <= fq.out_data;
                  arm_q   <= 1'b0;
                  state_q <= ST_WR;
               end
            ST_WR:
               state_q <= ST_WR;
            ST_DRAIN:
               if (!fq.out_valid)
               begin
                  busy_q  <= 1'b0;
                  state_q <= ST_IDLE;
               end
            default:
               state_q <= ST_IDLE;
         endcase
         if (step)
         begin
            arm_q <= 1'b0;
            if (!last)
               state_q <= (op_q == OP_TWRITE) ? ST_HOST : ST_SRC;
            else if (op_q == OP_READ)
               state_q <= ST_DRAIN;
            else
            begin
               busy_q  <= 1'b0;
               state_q <= ST_IDLE;
            end
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         addr_q  <= '0;
         wdata_q <= '0;
      end
      else if (en_i && !mem_req_o)
      begin
         addr_q  <= addr_d;
         wdata_q <= rop_mode ? rop_res : src_q;
      end
   end

   // ------------------------------------------------------------------
   // Pixel FIFO, shared by read and host-write paths
   // ------------------------------------------------------------------
   assign fq.clr       = start_ok;
   assign fq.in_valid  = (op_q == OP_READ) ? (state_q == ST_SRC) & rd_done
                       : (op_q == OP_TWRITE) & busy_q & host_wr_valid_i;
   assign fq.in_data   = (op_q == OP_READ) ? mem_rdata_i : host_wr_data_i;
   assign fq.out_ready = (op_q == OP_READ) ? host_rd_ready_i
                       : (state_q == ST_HOST);

   assign host_wr_ready_o = (op_q == OP_TWRITE) & busy_q & fq.in_ready;
   assign host_rd_valid_o = (op_q == OP_READ) & fq.out_valid;
   assign host_rd_data_o  = fq.out_data;

   bte_fifo #(.W(PIX_W), .DEPTH(DEPTH)) u_fifo (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .en_i  (en_i),
      .f     (fq.fifo)
   );

   // ------------------------------------------------------------------
   // Status and interrupt flags
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rd_flag_q <= 1'b0;
         wr_flag_q <= 1'b0;
         irq_n_q   <= 1'b1;
      end
      else if (en_i)
      begin
         rd_flag_q <= ((op_q == OP_READ) & fq.in_valid & fq.in_ready)
                    | (rd_flag_q & ~int_rd_clr_i);
         wr_flag_q <= ((state_q == ST_HOST) & fq.out_valid)
                    | (wr_flag_q & ~int_wr_clr_i);
         irq_n_q   <= ~((rd_flag_q & int_rd_en_i)
                    | (wr_flag_q & int_wr_en_i));
      end
   end

   assign ctrl_start_o  = busy_q;
   assign stat_busy_o   = busy_q;
   assign stat_xfer_o   = (op_q == OP_READ) ? fq.out_valid
                        : host_wr_ready_o;
   assign int_rd_flag_o = rd_flag_q;
   assign int_wr_flag_o = wr_flag_q;
   assign irq_n_o       = irq_n_q;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_start_busy: assert property (
      en_i && start_ok |=> busy_q)
      else $error("start did not raise busy");
   chk_done_count: assert property (
      $fell(busy_q) |-> idx_q == total_q)
      else $error("operation ended before all elements");
   chk_key_skip: assert property (mem_req_o && mem_we_o
      && (op_q == OP_TWRITE || op_q == OP_TMOVE) |-> mem_wdata_o != fg_q)
      else $error("transparent pixel written");
   chk_rop_write: assert property (
      mem_req_o && mem_we_o && rop_mode |-> mem_wdata_o == $past(rop_res))
      else $error("raster op result wrong");
   chk_neg_first: assert property ($rose(busy_q) && neg
      |-> x_q == w_q - 1'b1 && y_q == h_q - 1'b1)
      else $error("negative move not started at last element");
   chk_rd_flag: assert property (en_i && op_q == OP_READ
      && fq.in_valid && fq.in_ready |=> rd_flag_q)
      else $error("read flag not raised");
   chk_wr_flag: assert property (en_i && state_q == ST_HOST
      && fq.out_valid |=> wr_flag_q)
      else $error("write flag not raised");
   chk_irq_level: assert property (
      en_i && rd_flag_q && int_rd_en_i |=> !irq_n_o)
      else $error("interrupt not asserted");
   chk_read_hold: assert property (busy_q && op_q == OP_READ
      && fq.out_valid |=> busy_q)
      else $error("burst read ended with data pending");
   chk_req_stable: assert property (mem_req_o && !mem_gnt_i
      |=> $stable(mem_addr_o))
      else $error("memory address moved while waiting");

   cov_read_done: cover property (op_q == OP_READ ##1 $fell(busy_q));
   cov_skip_host: cover property (state_q == ST_HOST && step);
   cov_neg_done: cover property (neg ##1 $fell(busy_q));
endmodule

// >>> verif/bte_mem_model.sv
// Display memory model: one request at a time, read data after grant.
// Assumes the engine holds its request until it is granted.
module bte_mem_model (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Memory port
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [19:0] addr_i,
   input  wire logic [15:0] wdata_i,
   output logic             gnt_o,
   output logic             rvalid_o,
   output logic [15:0]      rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] m [4096];
   logic [15:0] rd_q;
   logic        slow_q;
   // Grant every other cycle so requests must be held
   assign gnt_o   = req_i & slow_q;
   // Outside a data beat the bus shows the inverse of the last word
   assign rdata_o = rvalid_o ? rd_q : ~rd_q;
   initial for (int i = 0; i < 4096; i++) m[i] = 16'h5000 + 16'(i);
   always @(posedge clk_i)
   begin
      slow_q   <= rst_i ? 1'b0 : ~slow_q;
      rvalid_o <= ~rst_i & gnt_o & ~we_i;
      if (gnt_o & ~we_i) rd_q <= m[addr_i[11:0]];
      if (gnt_o & we_i) m[addr_i[11:0]] <= wdata_i;
   end
endmodule

// >>> verif/bte_engine_tb.sv
// Bench for the block transfer engine: each operation against a memory.
// Assumes one clk_i domain and a memory filled with 5000h plus address.
module bte_engine_tb import bte_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 0, rst_i = 1, en_i = 1, start_i = 0, pat16_i = 0;
   logic src_linear_i = 0, dst_linear_i = 0, int_rd_en_i = 1;
   logic int_wr_en_i = 1, int_rd_clr_i = 0, int_wr_clr_i = 0;
   logic host_wr_valid_i = 0, host_rd_ready_i = 0;
   logic [7:0] oper_i = 8'h00;
   logic [15:0] src_hpos_i = 0, src_vpos_i = 0, dst_hpos_i = 0;
   logic [15:0] dst_vpos_i = 0, fg_color_i = 0, host_wr_data_i = 0;
   logic [9:0] width_i = 0, height_i = 0;
   logic ctrl_start_o, stat_busy_o, stat_xfer_o, int_rd_flag_o;
   logic int_wr_flag_o, irq_n_o, host_wr_ready_o, host_rd_valid_o;
   logic mem_req_o, mem_we_o, mem_gnt_i, mem_rvalid_i;
   logic [15:0] host_rd_data_o, mem_wdata_o, mem_rdata_i;
   logic [19:0] mem_addr_o;
   int err_total = 0, samples_checked = 0;
   always #10 clk_i = ~clk_i;
   bte_engine u_bte_engine (.clk_i, .rst_i, .en_i, .start_i, .oper_i,
      .src_hpos_i, .src_vpos_i, .dst_hpos_i, .dst_vpos_i, .src_linear_i,
      .dst_linear_i, .pat16_i, .width_i, .height_i, .fg_color_i,
      .int_rd_en_i, .int_wr_en_i, .int_rd_clr_i, .int_wr_clr_i,
      .ctrl_start_o, .stat_busy_o, .stat_xfer_o, .int_rd_flag_o,
      .int_wr_flag_o, .irq_n_o, .host_wr_valid_i, .host_wr_data_i,
      .host_wr_ready_o, .host_rd_valid_o, .host_rd_data_o, .host_rd_ready_i,
      .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_gnt_i,
      .mem_rvalid_i, .mem_rdata_i);
   bte_mem_model u_bte_mem_model (.clk_i, .rst_i, .req_i(mem_req_o),
      .we_i(mem_we_o), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
      .gnt_o(mem_gnt_i), .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
   task automatic summarize;
      if (err_total == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tick(inout int n);
      @(posedge clk_i);
      #1 n++;
      if (n > 3000)
      begin
         err_total++;
         summarize();
      end
   endtask
   task automatic run(logic [7:0] op, logic [15:0] dh, logic [9:0] w,
                      logic [9:0] h, logic l, logic eb);
      @(posedge clk_i);
      {oper_i, dst_hpos_i, width_i, height_i} <= {op, dh, w, h};
      {src_linear_i, dst_linear_i, start_i} <= {l, l, 1'b1};
      @(posedge clk_i);
      start_i <= 1'b0;
      #1 chk("busy", 16'(eb), 16'(stat_busy_o));
   endtask
   task automatic idle;
      int n = 0;
      while (stat_busy_o !== 1'b0) tick(n);
      chk("start", 16'h0, 16'(ctrl_start_o));
   endtask
   task automatic pop(output logic [15:0] d);
      int n = 0;
      while (host_rd_valid_o !== 1'b1) tick(n);
      d = host_rd_data_o;
      chk("xfer", 16'h1, 16'(stat_xfer_o));
      @(posedge clk_i);
      host_rd_ready_i <= 1'b1;
      @(posedge clk_i);
      host_rd_ready_i <= 1'b0;
      #1;
   endtask
   task automatic push(logic [15:0] d);
      int n = 0;
      @(posedge clk_i);
      {host_wr_valid_i, host_wr_data_i} <= {1'b1, d};
      #1;
      while (host_wr_ready_o !== 1'b1) tick(n);
      chk("xfer", 16'h1, 16'(stat_xfer_o));
      @(posedge clk_i);
      host_wr_valid_i <= 1'b0;
      #1;
   endtask
   task automatic clr;
      @(posedge clk_i);
      {int_rd_clr_i, int_wr_clr_i} <= 2'b11;
      @(posedge clk_i);
      {int_rd_clr_i, int_wr_clr_i} <= 2'b00;
      repeat (2) @(posedge clk_i);
      #1 chk("irq", 16'h1, 16'(irq_n_o));
   endtask
   initial
   begin
      logic [15:0] d;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      src_hpos_i <= 16'd4;
      // Burst read of a 5x2 block; host stalls until the queue fills
      run(8'h01, 16'd0, 10'd5, 10'd2, 1'b0, 1'b1);
      repeat (30) @(posedge clk_i);
      #1 chk("req", 16'h0, 16'(mem_req_o));
      chk("rflg", 16'h1, 16'(int_rd_flag_o));
      chk("irq", 16'h0, 16'(irq_n_o));
      for (int i = 0; i < 10; i++)
      begin
         chk("busy", 16'h1, 16'(stat_busy_o));
         pop(d);
         chk("rd", 16'h5004 + 16'(i / 5 * 800 + i % 5), d);
      end
      idle();
      clr();
      chk("rflg", 16'h0, 16'(int_rd_flag_o));
      run(8'h02, 16'd0, 10'd0, 10'd2, 1'b0, 1'b0);
      @(posedge clk_i);
      src_hpos_i <= 16'd0;
      run(8'hC2, 16'd200, 10'd2, 10'd2, 1'b1, 1'b1);
      idle();
      run(8'h33, 16'd210, 10'd2, 10'd2, 1'b1, 1'b1);
      idle();
      @(posedge clk_i);
      fg_color_i <= 16'h5001;
      run(8'h05, 16'd220, 10'd4, 10'd1, 1'b1, 1'b1);
      idle();
      run(8'hC6, 16'd230, 10'd2, 10'd1, 1'b0, 1'b1);
      idle();
      // Write flag raised with its interrupt enable off must not pull irq
      @(posedge clk_i);
      fg_color_i <= 16'h00F0;
      int_wr_en_i <= 1'b0;
      run(8'hC4, 16'd240, 10'd4, 10'd1, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) push(i == 1 ? 16'h00F0 : 16'hA000 + 16'(i));
      idle();
      chk("wflg", 16'h1, 16'(int_wr_flag_o));
      chk("irq", 16'h1, 16'(irq_n_o));
      @(posedge clk_i);
      int_wr_en_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 chk("irq", 16'h0, 16'(irq_n_o));
      clr();
      for (int i = 0; i < 4; i++)
      begin
         d = 16'h5000 + 16'(i);
         chk("mv+", d, u_bte_mem_model.m[200 + i]);
         chk("mv-", ~d, u_bte_mem_model.m[210 + i]);
         chk("tmv", i == 1 ? 16'h50DD : d,
             u_bte_mem_model.m[220 + i]);
         chk("tw", i == 1 ? 16'h50F1 : 16'hA000 + 16'(i),
             u_bte_mem_model.m[240 + i]);
         if (i < 2) chk("pf", d, u_bte_mem_model.m[230 + i]);
      end
      summarize();
   end
endmodule
